// >>> disk_word_data_path_tb.sv
// Self-checking bench for the disk word data path
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
    n_mismatch++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end

module disk_word_data_path_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int W = 16;
    logic mclk, srst, init, general_clear, function_start, count_overflow;
    logic stop_transfers, format_mode, addr_inc_inhibit, last_word_done;
    logic file_done, bit_clk, data_state, header_state, serial_disk_bit;
    logic last_sector, host_data_strobe, xfer_complete, da_load_lo;
    logic da_load_hi, ma_load_lo, ma_load_hi, serial_write_bit, input_full;
    logic output_full, data_late_flag, xfer_enable, xfer_request, slow;
    logic dma_bus_request, sector_count_pulse, cylinder_overflow;
    logic [15:0] load_data, disk_address_reg, memory_address_reg, v, m0;
    logic [W-1:0] host_data, output_word_reg, w;
    logic [W-1:0] exp_q[$];
    dwp_pkg::dwp_func_t func_mode;
    int n_mismatch = 0;
    int checks_done = 0;
    int k, b;

    dwp_data_path #(.WORD_W(W)) DUT (.*);
    dwp_host_model #(.W(W)) u_host (.*);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] da(logic [2:0] dr, logic [7:0] cy,
                                       logic su, logic [3:0] se);
        return {dr, cy, su, se};
    endfunction
    task automatic tick(int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Trailing cycle keeps two pulses from meeting in one time step
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
        tick();
    endtask
    task automatic load(bit to_da, logic [15:0] d);
        load_data = d;
        {da_load_lo, da_load_hi} = {2{to_da}};
        {ma_load_lo, ma_load_hi} = {2{!to_da}};
        tick();
        {da_load_lo, da_load_hi, ma_load_lo, ma_load_hi} = 4'h0;
        load_data = ~d;
        tick();
    endtask
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 300) begin
            tick();
            n++;
        end
        if (s !== 1'b1) n_mismatch++;
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge mclk);
        n_mismatch++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {srst, init, general_clear, function_start, count_overflow} = 5'h10;
        {stop_transfers, format_mode, addr_inc_inhibit} = 3'h0;
        {file_done, bit_clk, data_state, header_state} = 4'h0;
        {serial_disk_bit, last_sector, last_word_done, slow} = 4'h0;
        {da_load_lo, da_load_hi, ma_load_lo, ma_load_hi} = 4'h0;
        load_data = 16'h0000;
        func_mode = dwp_pkg::FN_READ;
        v = 16'($urandom(32'h2DA31F77));
        tick(12);
        srst = 1'b0;
        for (k = 0; k < 4; k++) begin
            v = (k == 0) ? 16'hFFFF : 16'($urandom);
            load(1'b1, v);
            `CHK("disk_address", v, disk_address_reg)
            load(1'b0, v);
            `CHK("mem_address", v, memory_address_reg)
        end
        pulse(init);
        `CHK("init", 32'h0, {disk_address_reg, memory_address_reg})
        m0 = 16'($urandom) & 16'hFFF0;
        load(1'b0, m0);
        slow = 1'b1;
        func_mode = dwp_pkg::FN_WRITE;
        pulse(general_clear);
        pulse(function_start);
        tick(150);
        // Out buffer, four file words and the input buffer hold six
        `CHK("taken", 6, u_host.sent_q.size())
        `CHK("input_full", 1'b1, input_full)
        `CHK("request", 1'b0, xfer_request)
        `CHK("mem_step", m0 + 16'h000C, memory_address_reg)
        slow = 1'b0;
        data_state = 1'b1;
        for (k = 0; k < 6; k++) begin
            func_mode = (k < 3) ? dwp_pkg::FN_WRITE : dwp_pkg::FN_WCHECK;
            for (b = 0; b < W; b++) begin
                wait_hi(output_full);
                w[b] = serial_write_bit;
                pulse(bit_clk);
            end
            `CHK("wr_word", u_host.sent_q[k], w)
        end
        pulse(stop_transfers);
        `CHK("enable", 1'b0, xfer_enable)
        repeat (8 * W) pulse(bit_clk);
        `CHK("late", 1'b1, data_late_flag)
        `CHK("out_full", 1'b0, output_full)
        pulse(init);
        `CHK("late_clr", 1'b0, data_late_flag)
        func_mode = dwp_pkg::FN_READ;
        addr_inc_inhibit = 1'b1;
        slow = 1'($urandom);
        pulse(general_clear);
        pulse(function_start);
        for (k = 0; k < 3; k++) begin
            format_mode = (k == 2);
            data_state = (k != 2);
            header_state = (k == 2);
            for (b = 0; b < W; b++) begin
                w[b] = 1'($urandom);
                serial_disk_bit = w[b];
                pulse(bit_clk);
            end
            exp_q.push_back(w);
        end
        tick(60);
        for (k = 0; k < 3; k++)
            `CHK("rd_word", exp_q[k], u_host.got_q[k])
        `CHK("no_step", 16'h0000, memory_address_reg)
        pulse(count_overflow);
        `CHK("enable", 1'b0, xfer_enable)
        func_mode = dwp_pkg::FN_RCHECK;
        pulse(function_start);
        `CHK("rchk_req", 1'b0, dma_bus_request)
        pulse(stop_transfers);
        load(1'b1, da(3'h2, 8'h05, 1'b1, 4'hB));
        last_sector = 1'b1;
        pulse(last_word_done);
        wait_hi(sector_count_pulse);
        tick();
        `CHK("cylinder_overflow", 1'b1, cylinder_overflow)
        tick();
        `CHK("head", da(3'h2, 8'h06, 1'b0, 4'h0), disk_address_reg)
        last_sector = 1'b0;
        pulse(last_word_done);
        wait_hi(sector_count_pulse);
        tick();
        `CHK("no_cylinder_overflow", 1'b0, cylinder_overflow)
        tick();
        `CHK("sector", da(3'h2, 8'h06, 1'b0, 4'h1), disk_address_reg)
        // File done holds back the cylinder overflow on a head change
        file_done = 1'b1;
        last_sector = 1'b1;
        load(1'b1, da(3'h2, 8'h06, 1'b1, 4'hB));
        pulse(last_word_done);
        wait_hi(sector_count_pulse);
        tick();
        `CHK("cyl_fd", 1'b0, cylinder_overflow)
        give_verdict();
    end
endmodule // disk_word_data_path_tb

`default_nettype wire

// >>> dwp_data_path.sv
// Disk word data path: buffers, word file, address counters
`include "dwp_map.svh"
`default_nettype none

module dwp_data_path #(
    parameter int WORD_W = 16
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   srst,
    // Status control
    input  wire dwp_pkg::dwp_func_t     func_mode,
    input  wire logic                   init,
    input  wire logic                   general_clear,
    input  wire logic                   function_start,
    input  wire logic                   count_overflow,
    input  wire logic                   stop_transfers,
    input  wire logic                   format_mode,
    input  wire logic                   addr_inc_inhibit,
    input  wire logic                   last_word_done,
    input  wire logic                   file_done,
    // Disk control
    input  wire logic                   bit_clk,
    input  wire logic                   data_state,
    input  wire logic                   header_state,
    input  wire logic                   serial_disk_bit,
    input  wire logic                   last_sector,
    // Host bus control
    input  wire logic                   host_data_strobe,
    input  wire logic [WORD_W-1:0]      host_data,
    input  wire logic                   xfer_complete,
    input  wire logic                   da_load_lo,
    input  wire logic                   da_load_hi,
    input  wire logic                   ma_load_lo,
    input  wire logic                   ma_load_hi,
    input  wire logic [15:0]            load_data,
    // Data out
    output var  logic                   serial_write_bit,
    output var  logic [WORD_W-1:0]      output_word_reg,
    // Status out
    output var  logic                   input_full,
    output var  logic                   output_full,
    output var  logic                   data_late_flag,
    output var  logic                   xfer_enable,
    output var  logic                   xfer_request,
    output var  logic                   dma_bus_request,
    output var  logic                   sector_count_pulse,
    output var  logic                   cylinder_overflow,
    // Addresses
    output var  logic [15:0]            disk_address_reg,
    output var  logic [15:0]            memory_address_reg
);
    localparam int SHW = `DWP_SHCNT_W;
    localparam logic [SHW-1:0] LAST_CNT = SHW'(WORD_W - 1);

    // ----------------------------------------------------------------
    // Function decode and shift pulses
    // ----------------------------------------------------------------
    logic is_read;
    logic is_wr;
    logic is_rchk;
    logic in_phase;
    logic in_shift_pulse;
    logic out_shift_pulse;
    logic late_in;
    logic late_out;
    logic last_bit;
    logic file_write_pulse;
    logic file_read_pulse;
    logic xc_fall;
    logic [SHW-1:0] shcnt_reg,     shcnt_next;
    logic [1:0]     in_idx_reg,    in_idx_next;
    logic [1:0]     out_idx_reg,   out_idx_next;
    logic           in_full_reg,   in_full_next;
    logic           out_full_reg,  out_full_next;
    logic           late_reg,      late_next;
    logic           xen_reg,       xen_next;
    logic           xreq_reg,      xreq_next;
    logic           busreq_reg;
    logic           xc_prev_reg;
    logic           sect_end_reg,  sect_end_next;
    logic           sect_cnt_reg,  sect_cnt_next;
    logic           cylinder_overflow_reg,   cylinder_overflow_next;
    logic           release_end;

    logic [WORD_W-1:0] in_q;
    logic [WORD_W-1:0] out_q;

    dwp_file_if #(.WORD_W(WORD_W)) fif ();

    always_comb begin
        is_read  = (func_mode == dwp_pkg::FN_READ);
        is_rchk  = (func_mode == dwp_pkg::FN_RCHECK);
        is_wr    = (func_mode == dwp_pkg::FN_WRITE) ||
                   (func_mode == dwp_pkg::FN_WCHECK);
        in_phase = format_mode ? header_state : data_state;
        // A shift into a full buffer is refused and reported late
        in_shift_pulse  = is_read && bit_clk && in_phase &&
                          !input_full;
        late_in         = is_read && bit_clk && in_phase &&
                          input_full;
        out_shift_pulse = is_wr && bit_clk && data_state &&
                          output_full;
        late_out        = is_wr && bit_clk && data_state &&
                          !output_full;
        last_bit = (in_shift_pulse || out_shift_pulse) &&
                   (shcnt_reg == LAST_CNT);
        file_write_pulse = input_full && !fif.full;
        file_read_pulse  = !fif.empty && !output_full;
        xc_fall = xc_prev_reg && !xfer_complete;
    end

    // ----------------------------------------------------------------
    // Buffers and file
    // ----------------------------------------------------------------
    dwp_shift_buf #(.WORD_W(WORD_W)) u_in_buf (
        .mclk      (mclk),
        .srst      (srst),
        .clear     (general_clear || file_write_pulse),
        .load      (is_wr && host_data_strobe),
        .load_data (host_data),
        .shift     (in_shift_pulse),
        .shift_in  (serial_disk_bit),
        .q         (in_q)
    );

    dwp_shift_buf #(.WORD_W(WORD_W)) u_out_buf (
        .mclk      (mclk),
        .srst      (srst),
        .clear     (1'b0),
        .load      (file_read_pulse),
        .load_data (fif.rd_data),
        .shift     (out_shift_pulse),
        .shift_in  (1'b0),
        .q         (out_q)
    );

    dwp_word_file #(.WORD_W(WORD_W)) u_file (
        .mclk (mclk),
        .srst (srst),
        .f    (fif)
    );

    assign fif.clear   = general_clear;
    assign fif.wr_en   = file_write_pulse;
    assign fif.wr_idx  = in_idx_reg;
    assign fif.wr_data = in_q;
    assign fif.rd_en   = file_read_pulse;
    assign fif.rd_idx  = out_idx_reg;

    // ----------------------------------------------------------------
    // Sequencing state
    // ----------------------------------------------------------------
    always_comb begin
        shcnt_next   = shcnt_reg;
        in_idx_next  = in_idx_reg;
        out_idx_next = out_idx_reg;
        if (in_shift_pulse || out_shift_pulse) begin
            shcnt_next = last_bit ? '0 : shcnt_reg + SHW'(1);
        end
        if (file_write_pulse) begin
            in_idx_next = in_idx_reg + 2'h1;
        end
        if (file_read_pulse) begin
            out_idx_next = out_idx_reg + 2'h1;
        end
        if (general_clear) begin
            in_idx_next  = '0;
            out_idx_next = '0;
            shcnt_next   = '0;
        end

        // Set wins over the file write that empties the buffer
        in_full_next = (is_read && in_shift_pulse && last_bit) ||
                       (is_wr && xfer_complete) ||
                       (in_full_reg && !file_write_pulse);

        out_full_next = out_full_reg;
        if (file_read_pulse) begin
            out_full_next = 1'b1;
        end else if ((out_shift_pulse && last_bit) ||
                     (is_read && xc_fall)) begin
            out_full_next = 1'b0;
        end
        if (general_clear) begin
            out_full_next = 1'b0;
        end

        late_next = late_in || late_out ||
                    (late_reg && !init);

        xen_next = xen_reg;
        if (count_overflow || stop_transfers) begin
            xen_next = 1'b0;
        end
        if (function_start) begin
            xen_next = 1'b1;
        end

        xreq_next = xen_reg && !is_rchk &&
                    ((is_wr && !in_full_reg) ||
                     (is_read && out_full_reg));

        // Sector end drops once the data path has settled
        release_end = !xen_reg ||
                      ((is_read || is_rchk) && fif.empty &&
                       !out_full_reg) ||
                      (is_wr && fif.full && in_full_reg);
        sect_end_next = last_word_done ||
                        (sect_end_reg && !release_end);
        sect_cnt_next = sect_end_reg && !sect_end_next;
        cylinder_overflow_next  = sect_cnt_reg && last_sector &&
                        disk_address_reg[`DWP_DA_SURF_BIT] &&
                        !file_done;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            shcnt_reg    <= '0;
            in_idx_reg   <= '0;
            out_idx_reg  <= '0;
            in_full_reg  <= 1'b0;
            out_full_reg <= 1'b0;
            late_reg     <= 1'b0;
            xen_reg      <= 1'b0;
            xreq_reg     <= 1'b0;
            busreq_reg   <= 1'b0;
            xc_prev_reg  <= 1'b0;
            sect_end_reg <= 1'b0;
            sect_cnt_reg <= 1'b0;
            cylinder_overflow_reg  <= 1'b0;
        end else begin
            shcnt_reg    <= shcnt_next;
            in_idx_reg   <= in_idx_next;
            out_idx_reg  <= out_idx_next;
            in_full_reg  <= in_full_next;
            out_full_reg <= out_full_next;
            late_reg     <= late_next;
            xen_reg      <= xen_next;
            xreq_reg     <= xreq_next;
            busreq_reg   <= xreq_reg;
            xc_prev_reg  <= xfer_complete;
            sect_end_reg <= sect_end_next;
            sect_cnt_reg <= sect_cnt_next;
            cylinder_overflow_reg  <= cylinder_overflow_next;
        end
    end

    // ----------------------------------------------------------------
    // Disk and memory address counters
    // ----------------------------------------------------------------
    logic [15:0] da_reg, da_next;
    logic [15:0] ma_reg, ma_next;

    always_comb begin
        da_next = da_reg;
        if (da_load_lo) begin
            da_next[7:0] = load_data[7:0];
        end
        if (da_load_hi) begin
            da_next[15:8] = load_data[15:8];
        end
        if (sect_cnt_reg && !da_load_lo && !da_load_hi) begin
            if (last_sector) begin
                // Head change: new surface, sector back to zero
                da_next[`DWP_DA_SECT_MSB:`DWP_DA_SECT_LSB] = 4'h0;
                da_next[`DWP_DA_SURF_BIT] =
                    !da_reg[`DWP_DA_SURF_BIT];
                if (da_reg[`DWP_DA_SURF_BIT]) begin
                    da_next[`DWP_DA_CYL_MSB:`DWP_DA_CYL_LSB] =
                        da_reg[`DWP_DA_CYL_MSB:`DWP_DA_CYL_LSB]
                        + 8'h01;
                end
            end else begin
                da_next[`DWP_DA_SECT_MSB:`DWP_DA_SECT_LSB] =
                    da_reg[`DWP_DA_SECT_MSB:`DWP_DA_SECT_LSB]
                    + 4'h1;
            end
        end
        if (init) begin
            da_next = `DWP_DA_RESET;
        end

        ma_next = ma_reg;
        if (ma_load_lo) begin
            ma_next[7:0] = load_data[7:0];
        end
        if (ma_load_hi) begin
            ma_next[15:8] = load_data[15:8];
        end
        if (xfer_complete && !addr_inc_inhibit &&
            !ma_load_lo && !ma_load_hi) begin
            ma_next = ma_reg + `DWP_MA_STEP;
        end
        if (init) begin
            ma_next = `DWP_MA_RESET;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            da_reg <= `DWP_DA_RESET;
            ma_reg <= `DWP_MA_RESET;
        end else begin
            da_reg <= da_next;
            ma_reg <= ma_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign serial_write_bit   = out_q[0];
    assign output_word_reg    = out_q;
    assign input_full         = in_full_reg;
    assign output_full        = out_full_reg;
    assign data_late_flag     = late_reg;
    assign xfer_enable        = xen_reg;
    assign xfer_request       = xreq_reg;
    assign dma_bus_request    = busreq_reg;
    assign sector_count_pulse = sect_cnt_reg;
    assign cylinder_overflow  = cylinder_overflow_reg;
    assign disk_address_reg   = da_reg;
    assign memory_address_reg = ma_reg;
endmodule // dwp_data_path

`default_nettype wire

// >>> dwp_data_path_checker.sv
// Port checks for the disk word data path
`default_nettype none

module dwp_data_path_checker (
    // Clock and reset
    input wire logic               mclk, srst,
    // Controls
    input wire logic               init, function_start, count_overflow,
    input wire logic               stop_transfers, addr_inc_inhibit,
    input wire logic               last_sector, xfer_complete,
    input wire logic               da_load_lo, da_load_hi,
    input wire logic               ma_load_lo, ma_load_hi,
    input wire dwp_pkg::dwp_func_t func_mode,
    // Outputs
    input wire logic               xfer_enable, xfer_request,
    input wire logic               dma_bus_request, data_late_flag,
    input wire logic               sector_count_pulse, cylinder_overflow,
    input wire logic [15:0]        disk_address_reg, memory_address_reg
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Loads and init win over any count, so those cycles are left out
    wire logic ma_free = !(init | ma_load_lo | ma_load_hi);
    wire logic da_free = !(init | da_load_lo | da_load_hi);

    AST_XEN_SET: assert property (function_start |=> xfer_enable)
        else $error("enable not set");
    AST_XEN_CLR: assert property (
        (count_overflow | stop_transfers) & !function_start |=> !xfer_enable)
        else $error("enable kept");
    AST_NO_RCHK: assert property (
        (func_mode == dwp_pkg::FN_RCHECK) [*3] |-> !xfer_request)
        else $error("request in read check");
    AST_BUS_REQ: assert property (
        $rose(xfer_request) |=> dma_bus_request) else $error("no bus request");
    AST_MA_STEP: assert property (
        xfer_complete & ma_free & !addr_inc_inhibit |=>
        memory_address_reg == $past(memory_address_reg) + 16'h0002)
        else $error("address step wrong");
    AST_INIT_CLR: assert property (
        init |=> {disk_address_reg, memory_address_reg} == 32'h0)
        else $error("init did not clear");
    AST_DLT_KEEP: assert property (
        data_late_flag & !init |=> data_late_flag) else $error("late lost");
    AST_SECT_INC: assert property (
        sector_count_pulse & !last_sector & da_free |=>
        disk_address_reg[3:0] == $past(disk_address_reg[3:0]) + 4'h1)
        else $error("sector not stepped");
    AST_HEAD_CHG: assert property (
        sector_count_pulse & last_sector & da_free |=>
        $changed(disk_address_reg[4]) && disk_address_reg[3:0] == 4'h0)
        else $error("head change wrong");
    AST_CYLINDER_OVERFLOW: assert property (
        cylinder_overflow |-> $past(sector_count_pulse) && !disk_address_reg[4])
        else $error("stray cylinder overflow");
    cover property (cylinder_overflow);
    cover property ($rose(data_late_flag));
    cover property ($rose(dma_bus_request));
endmodule // dwp_data_path_checker

bind dwp_data_path dwp_data_path_checker u_chk (.*);

`default_nettype wire

// >>> dwp_file_if.sv
// Carrier between the data path control and its four-word file
`default_nettype none

interface dwp_file_if #(
    parameter int WORD_W = 16
);
    logic              clear;
    logic              wr_en;
    logic [1:0]        wr_idx;
    logic [WORD_W-1:0] wr_data;
    logic              rd_en;
    logic [1:0]        rd_idx;
    logic [WORD_W-1:0] rd_data;
    logic              full;
    logic              empty;

    modport ctrl (
        output clear, wr_en, wr_idx, wr_data, rd_en, rd_idx,
        input  rd_data, full, empty
    );
    modport file (
        input  clear, wr_en, wr_idx, wr_data, rd_en, rd_idx,
        output rd_data, full, empty
    );
endinterface

`default_nettype wire

// >>> dwp_host_model.sv
// Host bus side model answering transfer requests
`default_nettype none

module dwp_host_model #(
    parameter int W = 16
) (
    // Clock, reset and pace
    input  wire logic               mclk, srst, dma_bus_request, slow,
    input  wire dwp_pkg::dwp_func_t func_mode,
    input  wire logic [W-1:0]       output_word_reg,
    // Transfer strobes
    output var  logic               host_data_strobe, xfer_complete,
    output var  logic [W-1:0]       host_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [W-1:0] sent_q[$];
    logic [W-1:0] got_q[$];
    logic [W-1:0] w;

    initial begin
        host_data_strobe = 1'b0;
        xfer_complete = 1'b0;
        host_data = '0;
        forever begin
            @(posedge mclk);
            #1;
            if (!srst && dma_bus_request) begin
                repeat (slow ? 4 : 0) begin
                    @(posedge mclk);
                    #1;
                end
                w = W'($urandom);
                if (func_mode == dwp_pkg::FN_READ) begin
                    got_q.push_back(output_word_reg);
                end else begin
                    host_data = w;
                    host_data_strobe = 1'b1;
                    @(posedge mclk);
                    #1;
                    host_data_strobe = 1'b0;
                    sent_q.push_back(w);
                end
                xfer_complete = 1'b1;
                @(posedge mclk);
                #1;
                xfer_complete = 1'b0;
                // Released lines flip so stale data cannot pass
                host_data = ~w;
                repeat (5) @(posedge mclk);
            end
        end
    end
endmodule // dwp_host_model

`default_nettype wire

// >>> dwp_map.svh
// Field positions, steps and sizes of the disk word data path
`ifndef DWP_MAP_SVH
`define DWP_MAP_SVH

// ----------------------------------------------------------------
// Word file
// ----------------------------------------------------------------
`define DWP_FILE_DEPTH      4
`define DWP_FILE_IDX_W      2

// ----------------------------------------------------------------
// Disk address fields
// ----------------------------------------------------------------
`define DWP_DA_SECT_LSB     0
`define DWP_DA_SECT_MSB     3
`define DWP_DA_SURF_BIT     4
`define DWP_DA_CYL_LSB      5
`define DWP_DA_CYL_MSB      12
`define DWP_DA_DRV_LSB      13
`define DWP_DA_DRV_MSB      15
`define DWP_DA_RESET        16'h0000

// ----------------------------------------------------------------
// Memory address
// ----------------------------------------------------------------
`define DWP_MA_STEP         16'h0002
`define DWP_MA_RESET        16'h0000

// ----------------------------------------------------------------
// Shift counter: four stages plus one for the wide option
// ----------------------------------------------------------------
`define DWP_SHCNT_W         5

`endif

// >>> dwp_pkg.sv
// Types shared by the disk word data path modules
`default_nettype none

package dwp_pkg;
    // Function in progress, decoded by the status control
    typedef enum logic [1:0] {
        FN_READ,
        FN_WRITE,
        FN_WCHECK,
        FN_RCHECK
    } dwp_func_t;
endpackage

`default_nettype wire

// >>> dwp_shift_buf.sv
// Parallel-load shift buffer that shifts toward bit 0
`default_nettype none

module dwp_shift_buf #(
    parameter int WORD_W = 16
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              srst,
    // Control
    input  wire logic              clear,
    input  wire logic              load,
    input  wire logic [WORD_W-1:0] load_data,
    input  wire logic              shift,
    input  wire logic              shift_in,
    // Content
    output var  logic [WORD_W-1:0] q
);
    logic [WORD_W-1:0] buf_reg;
    logic [WORD_W-1:0] buf_next;

    // New bit enters at the top, bit 0 falls out
    always_comb begin
        buf_next = buf_reg;
        if (clear) begin
            buf_next = '0;
        end else if (load) begin
            buf_next = load_data;
        end else if (shift) begin
            buf_next = {shift_in, buf_reg[WORD_W-1:1]};
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            buf_reg <= '0;
        end else begin
            buf_reg <= buf_next;
        end
    end

    assign q = buf_reg;
endmodule // dwp_shift_buf

`default_nettype wire

// >>> dwp_word_file.sv
// Four-word file with one occupancy flag per location
`include "dwp_map.svh"
`default_nettype none

module dwp_word_file #(
    parameter int WORD_W = 16
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // File port
    dwp_file_if.file  f
);
    localparam int DEPTH = `DWP_FILE_DEPTH;

    logic [WORD_W-1:0] mem_reg  [DEPTH];
    logic [WORD_W-1:0] mem_next [DEPTH];
    logic [DEPTH-1:0]  occ_reg;
    logic [DEPTH-1:0]  occ_next;

    // Read and write may hit different locations in one cycle
    always_comb begin
        mem_next = mem_reg;
        occ_next = occ_reg;
        if (f.wr_en) begin
            mem_next[f.wr_idx] = f.wr_data;
        end
        if (f.rd_en) begin
            occ_next[f.rd_idx] = 1'b0;
        end
        if (f.wr_en) begin
            occ_next[f.wr_idx] = 1'b1;
        end
        if (f.clear) begin
            occ_next = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            occ_reg <= '0;
        end else begin
            occ_reg <= occ_next;
        end
        mem_reg <= mem_next;
    end

    assign f.rd_data = mem_reg[f.rd_idx];
    assign f.full    = &occ_reg;
    assign f.empty   = ~|occ_reg;
endmodule // dwp_word_file

`default_nettype wire
